// >>> cit_pkg.sv
// Constants, types and register map of the instruction-cycle sequencer
package cit_pkg;

   // Register bus geometry
   localparam int unsigned AXI_ADDR_W = 12;
   localparam int unsigned AXI_DATA_W = 32;
   localparam logic [1:0]  RESP_OKAY  = 2'b00;

   // Widths of the core datapath
   localparam int unsigned PC_W    = 13;
   localparam int unsigned INSTR_W = 14;
   localparam int unsigned DATA_W  = 8;

   // Register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_INDIRECT_DATA_PORT         = 8'h00;
   localparam logic [7:0] IDX_PROGRAM_COUNTER_LOW        = 8'h02;
   localparam logic [7:0] IDX_CORE_STATUS                = 8'h03;
   localparam logic [7:0] IDX_INDIRECT_POINTER           = 8'h04;
   localparam logic [7:0] IDX_PROGRAM_COUNTER_HIGH_LATCH = 8'h0a;
   localparam logic [7:0] IDX_INTERRUPT_CONTROL          = 8'h0b;
   localparam logic [7:0] IDX_POWER_RESET_FLAGS          = 8'h8e;
   localparam int unsigned MIRROR_BIT                    = 7;

   // Field positions
   localparam int unsigned ST_BANK_SEL   = 5;
   localparam int unsigned ST_TIMEOUT    = 4;
   localparam int unsigned ST_POWERDOWN  = 3;
   localparam int unsigned ST_ZERO       = 2;
   localparam int unsigned PRF_BROWNOUT  = 0;
   localparam int unsigned PRF_POWER_ON  = 1;
   localparam logic [7:0]  ST_KEEP_MASK  = 8'h1f;
   localparam logic [7:0]  ST_SW_MASK    = 8'he7;
   localparam logic [7:0]  IC_KEEP_MASK  = 8'h01;

   // Power-on values
   localparam logic [7:0] STATUS_POR = 8'h18;
   localparam logic [7:0] FSR_POR    = 8'h00;
   localparam logic [7:0] INTERRUPT_CONTROL_POR = 8'h00;
   localparam logic [4:0] PROGRAM_COUNTER_HIGH_LATCH_RST = 5'h00;
   localparam logic [1:0] POWER_RESET_FLAGS_POR   = 2'h0;

   // Instruction fields
   localparam logic [2:0] OPC_JUMP  = 3'h5;
   localparam logic [1:0] OPC_BYTE  = 2'h0;
   localparam int unsigned DEST_BIT = 7;
   localparam int unsigned INCR_BIT = 8;

   typedef enum logic [1:0] {
      ph_first, ph_second, ph_third, ph_fourth
   } cit_phase_type;

   typedef enum logic [2:0] {
      sel_none, sel_indirect_data_port, sel_pcl, sel_status, sel_fsr, sel_program_counter_high_latch, sel_interrupt_control, sel_power_reset_flags
   } cit_sel_type;

   // Data memory request
   typedef struct packed {
      logic [7:0] addr;
      logic       rd;
      logic       wr;
      logic [7:0] wdata;
   } cit_dm_req_type;

   typedef struct packed {
      cit_phase_type  phase;
      logic [12:0]    pc;
      logic [12:0]    fetch_addr;
      logic [13:0]    fetch_buf;
      logic           fetch_ok;
      logic [13:0]    ir;
      logic           ex_valid;
      logic           op_int;
      logic [7:0]     op_addr;
      logic [7:0]     result;
      cit_dm_req_type dm;
      logic [4:0]     program_counter_high_latch;
      logic [7:0]     status;
      logic [7:0]     indirect_pointer;
      logic [7:0]     interrupt_control;
      logic [1:0]     power_reset_flags;
      logic           aw_got;
      logic [7:0]     aw_idx;
      logic           w_got;
      logic [7:0]     wdata;
      logic           wen;
      logic           bvalid;
      logic           rvalid;
      logic [7:0]     rdata;
   } cit_state_type;

   localparam cit_state_type ST_POR = '{phase: ph_first, status: STATUS_POR, default: '0};

endpackage

// >>> cit_core_cycle.sv
// Four-phase instruction-cycle sequencer with core registers on AXI4-Lite
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps

module cit_core_cycle (
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   input  wire logic                    master_clear_req,
   input  wire logic                    bor_req,
   input  wire logic                    wdt_req,
   output logic [12:0]                  pm_addr,
   input  wire logic [13:0]             pm_rdata,
   output cit_pkg::cit_dm_req_type      dm_req,
   input  wire logic [7:0]              dm_rdata,
   output logic [3:0]                   phase_clocks,
   input  wire logic [11:0]             s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [11:0]             s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);

   cit_pkg::cit_state_type st_r;
   cit_pkg::cit_state_type st_nxt;
   logic                   other_rst;
   logic                   bus_wr_fire;
   cit_pkg::cit_sel_type   bus_wr_sel;
   cit_pkg::cit_sel_type   bus_rd_sel;
   cit_pkg::cit_sel_type   op_sel;
   logic [7:0]             op_full;
   logic                   ex_jump;
   logic                   ex_byte;

   // Map an 8-bit register index onto a core register
   function automatic cit_pkg::cit_sel_type sfr_sel(input logic [7:0] idx);
      logic [7:0] base;
      base = {1'b0, idx[6:0]};
      if (idx == cit_pkg::IDX_POWER_RESET_FLAGS) begin
         return cit_pkg::sel_power_reset_flags;
      end
      unique case (base)
         cit_pkg::IDX_INDIRECT_DATA_PORT:         return cit_pkg::sel_indirect_data_port;
         cit_pkg::IDX_PROGRAM_COUNTER_LOW:        return cit_pkg::sel_pcl;
         cit_pkg::IDX_CORE_STATUS:                return cit_pkg::sel_status;
         cit_pkg::IDX_INDIRECT_POINTER:           return cit_pkg::sel_fsr;
         cit_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH: return cit_pkg::sel_program_counter_high_latch;
         cit_pkg::IDX_INTERRUPT_CONTROL:          return cit_pkg::sel_interrupt_control;
         default:                                 return cit_pkg::sel_none;
      endcase
   endfunction

   // Read a core register; holes and unused bits return zero
   function automatic logic [7:0] sfr_read(input cit_pkg::cit_sel_type sel,
                                           input cit_pkg::cit_state_type s);
      unique case (sel)
         cit_pkg::sel_pcl:    return s.pc[7:0];
         cit_pkg::sel_status: return s.status;
         cit_pkg::sel_fsr:    return s.indirect_pointer;
         cit_pkg::sel_program_counter_high_latch: return {3'h0, s.program_counter_high_latch};
         cit_pkg::sel_interrupt_control: return s.interrupt_control;
         cit_pkg::sel_power_reset_flags:   return {6'h00, s.power_reset_flags};
         default:             return 8'h00;
      endcase
   endfunction

   // Store into a core register; a counter write also voids the prefetch
   function automatic cit_pkg::cit_state_type sfr_write(input cit_pkg::cit_state_type s,
                                                        input cit_pkg::cit_sel_type sel,
                                                        input logic [7:0] d);
      cit_pkg::cit_state_type r;
      r = s;
      unique case (sel)
         cit_pkg::sel_pcl: begin
            r.pc       = {s.program_counter_high_latch, d};
            r.fetch_ok = 1'b0;
         end
         // Timeout and power-down flags are hardware-owned
         cit_pkg::sel_status: r.status = (d & cit_pkg::ST_SW_MASK)
                                         | (s.status & ~cit_pkg::ST_SW_MASK);
         cit_pkg::sel_fsr:    r.indirect_pointer    = d;
         cit_pkg::sel_program_counter_high_latch: r.program_counter_high_latch = d[4:0];
         cit_pkg::sel_interrupt_control: r.interrupt_control = d;
         cit_pkg::sel_power_reset_flags:   r.power_reset_flags   = d[1:0];
         default:             r = s;
      endcase
      return r;
   endfunction

   // Byte-oriented file operation
   function automatic logic is_byte_op(input logic [13:0] w);
      return w[13:12] == cit_pkg::OPC_BYTE;
   endfunction

   // Operand address; a zero file field means indirect through the pointer
   function automatic logic [7:0] operand_addr(input logic [13:0]          w,
                                               input cit_pkg::cit_state_type s);
      return (w[6:0] == 7'h00) ? s.indirect_pointer : {s.status[cit_pkg::ST_BANK_SEL], w[6:0]};
   endfunction

   assign other_rst   = master_clear_req | bor_req | wdt_req;
   assign bus_wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
   assign bus_wr_sel  = sfr_sel(st_r.aw_idx);
   assign bus_rd_sel  = sfr_sel(s_axi_araddr[9:2]);
   assign ex_jump     = st_r.ex_valid & (st_r.ir[13:11] == cit_pkg::OPC_JUMP);
   assign ex_byte     = st_r.ex_valid & is_byte_op(st_r.ir);

   // Operand of the word about to enter the instruction register, so the read goes out early
   assign op_full = operand_addr(st_r.fetch_buf, st_r);
   assign op_sel  = sfr_sel(op_full);

   // Next-state logic: phase sequencer, pipeline, core registers and bus slave
   always_comb begin
      st_nxt        = st_r;
      st_nxt.dm.rd  = 1'b0;
      st_nxt.dm.wr  = 1'b0;
      st_nxt.phase  = cit_pkg::cit_phase_type'(st_r.phase + 2'h1);

      unique case (st_r.phase)
         cit_pkg::ph_first: begin
            st_nxt.fetch_addr = st_r.pc;
            st_nxt.pc         = st_r.pc + 13'h0001;
            st_nxt.ir         = st_r.fetch_buf;
            st_nxt.ex_valid   = st_r.fetch_ok;
            // Operand read is issued so that it stands through the second phase
            st_nxt.op_addr    = op_full;
            st_nxt.op_int     = (op_sel != cit_pkg::sel_none);
            st_nxt.dm.addr    = op_full;
            st_nxt.dm.rd      = st_r.fetch_ok & is_byte_op(st_r.fetch_buf)
                                & (op_sel == cit_pkg::sel_none);
         end
         cit_pkg::ph_second: begin
            // Read strobe is on the memory port now; address is kept for the write
            st_nxt.dm.addr = st_r.dm.addr;
         end
         cit_pkg::ph_third: begin
            // External data arrives one phase after the read strobe
            st_nxt.result = (st_r.op_int ? sfr_read(sfr_sel(st_r.op_addr), st_r) : dm_rdata)
                            + {7'h00, st_r.ir[cit_pkg::INCR_BIT]};
            st_nxt.dm.wdata = st_nxt.result;
            st_nxt.dm.wr    = ex_byte & ~st_r.op_int & st_r.ir[cit_pkg::DEST_BIT];
         end
         cit_pkg::ph_fourth: begin
            st_nxt.fetch_buf = pm_rdata;
            st_nxt.fetch_ok  = 1'b1;
            if (ex_byte) begin
               st_nxt.status[cit_pkg::ST_ZERO] = (st_r.result == 8'h00);
               if (st_r.op_int && st_r.ir[cit_pkg::DEST_BIT]) begin
                  st_nxt = sfr_write(st_nxt, sfr_sel(st_r.op_addr), st_r.result);
               end
            end
            if (ex_jump) begin
               st_nxt.pc       = {st_r.program_counter_high_latch[4:3], st_r.ir[10:0]};
               st_nxt.fetch_ok = 1'b0;
            end
         end
      endcase

      // Bus write channels are taken independently, in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.aw_idx = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = s_axi_wdata[7:0];
         st_nxt.wen   = s_axi_wstrb[0];
      end
      // Bus write lands after the core update, so software wins a same-cycle clash
      if (bus_wr_fire) begin
         if (st_r.wen) begin
            st_nxt = sfr_write(st_nxt, bus_wr_sel, st_r.wdata);
         end
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // Read answer one cycle after the address is taken
      if (s_axi_arvalid && s_axi_arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = sfr_read(bus_rd_sel, st_r);
      end else if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // Non-power-up resets: core restarts, bus slave and pointer survive
      if (other_rst) begin
         st_nxt.phase     = cit_pkg::ph_first;
         st_nxt.pc        = 13'h0000;
         st_nxt.fetch_ok  = 1'b0;
         st_nxt.ex_valid  = 1'b0;
         st_nxt.dm.rd     = 1'b0;
         st_nxt.dm.wr     = 1'b0;
         st_nxt.program_counter_high_latch    = cit_pkg::PROGRAM_COUNTER_HIGH_LATCH_RST;
         st_nxt.status    = st_r.status & cit_pkg::ST_KEEP_MASK;
         st_nxt.interrupt_control    = st_r.interrupt_control & cit_pkg::IC_KEEP_MASK;
         if (wdt_req) begin
            st_nxt.status[cit_pkg::ST_TIMEOUT] = 1'b0;
         end
         if (bor_req) begin
            st_nxt.status[cit_pkg::ST_TIMEOUT]   = 1'b1;
            st_nxt.status[cit_pkg::ST_POWERDOWN] = 1'b1;
            st_nxt.power_reset_flags[cit_pkg::PRF_BROWNOUT]   = 1'b0;
         end
      end
   end

   // Power-on reset loads the full reset image
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r <= cit_pkg::ST_POR;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign pm_addr       = st_r.fetch_addr;
   assign dm_req        = st_r.dm;
   assign phase_clocks  = 4'h1 << st_r.phase;
   assign s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
   assign s_axi_wready  = ~st_r.w_got & ~st_r.bvalid;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = cit_pkg::RESP_OKAY;
   assign s_axi_arready = ~st_r.rvalid;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = {24'h000000, st_r.rdata};
   assign s_axi_rresp   = cit_pkg::RESP_OKAY;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence seq_calm3;
      !other_rst [*3];
   endsequence

   // Prefetch dropped, then a whole cycle with nothing executing
   sequence seq_bubble;
      !st_r.fetch_ok ##1 !st_r.ex_valid [*4];
   endsequence

   a_phase_quad_order: assert property (
      (st_r.phase == cit_pkg::ph_first) ##0 seq_calm3
      |=> st_r.phase == cit_pkg::ph_fourth && $past(st_r.phase) == cit_pkg::ph_third
          && $past(st_r.phase, 2) == cit_pkg::ph_second)
      else $error("phase order broken");

   a_phase_one_hot: assert property ($onehot(phase_clocks))
      else $error("phase clocks overlap");

   a_pc_first_step: assert property (
      (st_r.phase == cit_pkg::ph_first && !other_rst && !(bus_wr_fire && st_r.wen))
      |=> st_r.pc == $past(st_r.pc) + 13'h0001 && st_r.fetch_addr == $past(st_r.pc))
      else $error("counter did not step in first phase");

   a_fetch_latch_fourth: assert property (
      (st_r.phase == cit_pkg::ph_fourth && !other_rst) |=> st_r.fetch_buf == $past(pm_rdata))
      else $error("fetch word not latched in fourth phase");

   a_ir_load_first: assert property (
      (st_r.phase == cit_pkg::ph_first && !other_rst)
      |=> st_r.ir == $past(st_r.fetch_buf) && st_r.ex_valid == $past(st_r.fetch_ok))
      else $error("instruction register not loaded");

   a_jump_flush_cycle: assert property (
      (st_r.phase == cit_pkg::ph_fourth && ex_jump && !other_rst && !bus_wr_fire)
      |=> seq_bubble)
      else $error("prefetched word survived a jump");

   a_read_second_phase: assert property (
      dm_req.rd |-> st_r.phase == cit_pkg::ph_second && $past(st_r.phase) == cit_pkg::ph_first)
      else $error("operand read outside second phase");

   a_write_fourth_phase: assert property (
      dm_req.wr |-> st_r.phase == cit_pkg::ph_fourth && $past(st_r.phase) == cit_pkg::ph_third)
      else $error("result write outside fourth phase");

   a_soft_reset_values: assert property (
      (master_clear_req && !wdt_req && !bor_req)
      |=> st_r.pc == 13'h0000 && st_r.program_counter_high_latch == 5'h00 && st_r.status[7:5] == 3'h0
          && st_r.status[4:3] == $past(st_r.status[4:3]) && st_r.indirect_pointer == $past(st_r.indirect_pointer))
      else $error("master clear values wrong");

   a_unimpl_reads_zero: assert property (
      (s_axi_arvalid && s_axi_arready && bus_rd_sel == cit_pkg::sel_none)
      |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
      else $error("unimplemented location not zero");

   a_mirror_same_reg: assert property (
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == 8'h83)
      |=> s_axi_rdata[7:0] == $past(st_r.status))
      else $error("mirror read differs");

   a_jump_target_load: assert property (
      (st_r.phase == cit_pkg::ph_fourth && ex_jump && !other_rst && !bus_wr_fire)
      |=> st_r.pc == {$past(st_r.program_counter_high_latch[4:3]), $past(st_r.ir[10:0])})
      else $error("jump target not loaded");

   a_watchdog_flag: assert property (
      (wdt_req && !bor_req) |=> !st_r.status[cit_pkg::ST_TIMEOUT] && st_r.pc == 13'h0000)
      else $error("watchdog reset values wrong");

   a_brownout_flags: assert property (
      bor_req |=> !st_r.power_reset_flags[cit_pkg::PRF_BROWNOUT] && st_r.status[4:3] == 2'b11
                  && st_r.program_counter_high_latch == 5'h00)
      else $error("brown-out reset values wrong");

   a_write_answer: assert property (
      bus_wr_fire |=> s_axi_bvalid && s_axi_bresp == cit_pkg::RESP_OKAY)
      else $error("write response missing");

   a_read_answer: assert property (
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && s_axi_rresp == cit_pkg::RESP_OKAY)
      else $error("read response missing");

   a_latch_bits_zero: assert property (
      (s_axi_arvalid && s_axi_arready && bus_rd_sel == cit_pkg::sel_program_counter_high_latch)
      |=> s_axi_rdata[7:5] == 3'h0)
      else $error("unused latch bits not zero");

endmodule

// >>> cit_mem_model.sv
// Program and data memory partner of the instruction-cycle sequencer
`timescale 1ns/10ps
module cit_mem_model (
   input  wire logic                    clk_sys,
   input  wire logic [12:0]             pm_addr,
   output logic [13:0]                  pm_rdata,
   input  wire cit_pkg::cit_dm_req_type dm_req,
   output logic [7:0]                   dm_rdata
);
   logic [7:0] mem_r [0:255];

   // Program: increments of file 0x20, and a jump to zero at each address ending in 8
   assign pm_rdata = (pm_addr[3:0] == 4'h8) ? 14'h2800 : 14'h01a0;

   // Read data is good for one cycle only, then turns over so a late sample shows
   always @(posedge clk_sys) begin
      if (dm_req.rd) begin
         dm_rdata <= mem_r[dm_req.addr];
      end else begin
         dm_rdata <= ~dm_rdata;
      end
      if (dm_req.wr) begin
         mem_r[dm_req.addr] <= dm_req.wdata;
      end
   end

   // Storage starts cleared so the bench can track file 0x20
   initial begin
      dm_rdata = 8'h00;
      for (int i = 0; i < 256; i++) begin
         mem_r[i] = 8'h00;
      end
   end
endmodule

// >>> tb_top.sv
// Self-checking bench of the instruction-cycle sequencer
`timescale 1ns/10ps
module tb_top;
   logic                    clk_sys, reset, master_clear_req, bor_req, wdt_req, mon_on;
   logic [12:0]             pm_addr;
   logic [13:0]             pm_rdata;
   cit_pkg::cit_dm_req_type dm_req;
   logic [7:0]              dm_rdata, shadow, d, f, c, st43;
   logic [3:0]              phase_clocks, s_axi_wstrb;
   logic [11:0]             s_axi_awaddr, s_axi_araddr;
   logic [31:0]             s_axi_wdata, s_axi_rdata;
   logic [1:0]              s_axi_bresp, s_axi_rresp;
   logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                    s_axi_rvalid, s_axi_rready;
   int                      miscompares, checks_done, seed, cycles, cyc, ph;
   logic [7:0]              reg_idx [5];
   logic [7:0]              reg_msk [5];

   cit_core_cycle DUT (.clk_sys, .reset, .master_clear_req, .bor_req, .wdt_req, .pm_addr, .pm_rdata,
      .dm_req, .dm_rdata, .phase_clocks, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   cit_mem_model mem (.clk_sys, .pm_addr, .pm_rdata, .dm_req, .dm_rdata);

   // Free-running 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever begin
         #2.5 clk_sys = ~clk_sys;
      end
   end

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Hang guard: the whole run needs well under 3000 cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         finish_test;
      end
   end

   // Readies are peeked at the falling edge, where they equal what the next rising edge samples
   task automatic axi_wr(input logic [7:0] idx, input logic [7:0] v);
      logic       aw_ok, w_ok, b_ok;
      logic [1:0] rsp;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= {2'b00, idx, 2'b00};
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(negedge clk_sys);
         aw_ok = aw_ok || (s_axi_awvalid && s_axi_awready);
         w_ok = w_ok || (s_axi_wvalid && s_axi_wready);
         @(posedge clk_sys);
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
      end
      do begin
         @(negedge clk_sys);
         b_ok = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge clk_sys);
      end while (!b_ok);
      check("bresp", rsp, cit_pkg::RESP_OKAY);
   endtask

   task automatic expect_reg(input string n, input logic [7:0] idx, input logic [7:0] msk,
                             input logic [7:0] e);
      logic        ok;
      logic [31:0] v;
      logic [1:0]  rsp;
      s_axi_araddr <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge clk_sys);
         ok = s_axi_arready;
         @(posedge clk_sys);
      end while (!ok);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge clk_sys);
         ok = s_axi_rvalid;
         v = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge clk_sys);
      end while (!ok);
      check("rresp", rsp, cit_pkg::RESP_OKAY);
      check("rdata_upper", v[31:8], 32'h0);
      check(n, v[7:0] & msk, e);
   endtask

   // Cycle n executes the word fetched in n-1; the loop of ten holds the jump and its bubble
   function automatic logic exec_at(input int n);
      return (n % 10) inside {[1:8]};
   endfunction

   // Phase, fetch and data memory strobes against the four-phase schedule
   always @(negedge clk_sys) begin
      if (mon_on) begin
         check("phase", phase_clocks, 32'h1 << ph);
         check("dm_rd", dm_req.rd, (ph == 1) && exec_at(cyc));
         check("dm_wr", dm_req.wr, (ph == 3) && exec_at(cyc));
         if (ph == 3) begin
            check("fetch", pm_addr, cyc % 10);
            if (dm_req.wr === 1'b1) begin
               check("result", {dm_req.addr, dm_req.wdata}, {8'h20, shadow + 8'h01});
               shadow = dm_req.wdata;
            end
            cyc++;
         end
         ph = (ph + 1) % 4;
      end
   end

   initial begin
      seed = 32'h67c6;
      {reset, mon_on, cycles, cyc, ph, shadow} = {1'b1, 1'b0, 32'd0, 32'd0, 32'd0, 8'h00};
      {master_clear_req, bor_req, wdt_req, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = {2'b11, 4'h1};
      reg_idx = '{cit_pkg::IDX_CORE_STATUS, cit_pkg::IDX_INDIRECT_POINTER,
                  cit_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH, cit_pkg::IDX_INTERRUPT_CONTROL,
                  cit_pkg::IDX_POWER_RESET_FLAGS};
      reg_msk = '{8'h23, 8'hff, 8'h1f, 8'hff, 8'h03};
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      mon_on <= 1'b1;
      repeat (160) @(posedge clk_sys);
      mon_on <= 1'b0;
      $display("test pipeline done");
      // Power-on values; zero flag moves with the running program so it is masked
      for (int i = 0; i < 5; i++) begin
         expect_reg("por", reg_idx[i], (i == 0) ? 8'hfb : 8'hff,
                    (i == 0) ? 8'h18 : 8'h00);
      end
      // Indirect port and holes in the map read as zero
      foreach (reg_idx[i]) expect_reg("hole", 8'h07 + 8'(i * 8), 8'hff, 8'h00);
      expect_reg("indirect", cit_pkg::IDX_INDIRECT_DATA_PORT, 8'hff, 8'h00);
      $display("test map done");
      // Random writes, read back at the base address and, except for the reset flags, its mirror
      repeat (3) begin
         for (int i = 0; i < 5; i++) begin
            d = 8'($random(seed));
            if (i == 0) d = d & 8'h3f;
            axi_wr(reg_idx[i], d);
            c = (d & reg_msk[i]) | ((i == 0) ? 8'h18 : 8'h00);
            expect_reg("reg", reg_idx[i], (i == 0) ? 8'hfb : 8'hff, c);
            if (i < 4) begin
               expect_reg("mirror", reg_idx[i] | 8'h80, (i == 0) ? 8'hfb : 8'hff, c);
            end
         end
      end
      // A write whose low byte strobe is off must leave the register alone
      axi_wr(cit_pkg::IDX_INDIRECT_POINTER, 8'h3c);
      s_axi_wstrb <= 4'h0;
      axi_wr(cit_pkg::IDX_INDIRECT_POINTER, 8'hc3);
      s_axi_wstrb <= 4'h1;
      expect_reg("no_strobe", cit_pkg::IDX_INDIRECT_POINTER, 8'hff, 8'h3c);
      $display("test registers done");
      // Master clear, watchdog and brown-out in turn
      st43 = 8'h18;
      for (int k = 0; k < 3; k++) begin
         {d, f, c} = 24'($random(seed));
         d = d & 8'h3f;
         axi_wr(cit_pkg::IDX_CORE_STATUS, d);
         axi_wr(cit_pkg::IDX_INDIRECT_POINTER, f);
         axi_wr(cit_pkg::IDX_INTERRUPT_CONTROL, c);
         axi_wr(cit_pkg::IDX_POWER_RESET_FLAGS, 8'h03);
         master_clear_req <= (k == 0);
         wdt_req <= (k == 1);
         bor_req <= (k == 2);
         @(posedge clk_sys);
         {master_clear_req, wdt_req, bor_req} <= 3'b000;
         st43 = (k == 1) ? (st43 & 8'h08) : ((k == 2) ? 8'h18 : st43);
         expect_reg("soft_status", cit_pkg::IDX_CORE_STATUS, 8'hfb, st43 | (d & 8'h03));
         expect_reg("soft_ptr", cit_pkg::IDX_INDIRECT_POINTER, 8'hff, f);
         expect_reg("soft_intc", cit_pkg::IDX_INTERRUPT_CONTROL, 8'hff, c & 8'h01);
         expect_reg("soft_latch", cit_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH, 8'hff, 8'h00);
         expect_reg("soft_flags", cit_pkg::IDX_POWER_RESET_FLAGS, 8'hff,
                    (k == 2) ? 8'h02 : 8'h03);
      end
      $display("test soft resets done");
      finish_test;
   end
endmodule
